/* File: logic/acd_pkg.sv */
/*
  Shared constants for the add/compare/decrement execution sequencer:
  opcode fields, supported operation and mode codes, reset values and
  the cycle counts of the fetch and of the four instructions whose length is asserted.
  Assumes an 8-bit data path and 8-bit memory and port address spaces.
*/
package acd_pkg;

  localparam int DATA_W = 8;
  localparam int OP_W = 5;
  localparam int MODE_W = 3;

  // Opcode field positions
  localparam int OP_HI = 7;
  localparam int OP_LO = 3;
  localparam int MODE_HI = 2;
  localparam int MODE_LO = 0;

  // Operation codes (upper five opcode bits)
  localparam logic [OP_W-1:0] OP_PORT_READ = 5'h01;
  localparam logic [OP_W-1:0] OP_COMPARE = 5'h07;
  localparam logic [OP_W-1:0] OP_ADD = 5'h0c;
  localparam logic [OP_W-1:0] OP_MINUS_ONE = 5'h0e;

  // Addressing modes (lower three opcode bits)
  localparam logic [MODE_W-1:0] MODE_DIRECT = 3'h0;
  localparam logic [MODE_W-1:0] MODE_REG_ACC = 3'h2;
  localparam logic [MODE_W-1:0] MODE_REG_INDEX = 3'h3;
  localparam logic [MODE_W-1:0] MODE_INDIRECT = 3'h4;
  localparam logic [MODE_W-1:0] MODE_IMMEDIATE = 3'h6;

  // Full opcodes used for cycle checks
  localparam logic [DATA_W-1:0] OPC_ADD_IMM = 8'h66;
  localparam logic [DATA_W-1:0] OPC_CMP_DIR = 8'h38;
  localparam logic [DATA_W-1:0] OPC_DEC_DIR = 8'h70;
  localparam logic [DATA_W-1:0] OPC_PORT_DIR = 8'h08;

  // Instruction lengths in clock cycles
  localparam int CYC_FETCH = 3;
  localparam int CYC_ADD_IMM = 6;
  localparam int CYC_CMP_DIR = 9;
  localparam int CYC_DEC_DIR = 11;
  localparam int CYC_PORT_DIR = 9;

  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
  localparam logic [DATA_W-1:0] TWO_BYTE = 8'h02;
  localparam logic [7:0] LEN_ONE = 8'h01;

  typedef enum logic [3:0] {
    ST_FETCH_ADDR, ST_FETCH_DATA, ST_FETCH_LOAD,
    ST_B2_ADDR, ST_B2_DATA, ST_MOVE_OPND, ST_OPND_FROM_INDEX,
    ST_OPND_ADDR, ST_OPND_DATA, ST_LOAD_ACC, ST_DEC_HOLD,
    ST_EXEC, ST_ACC_TO_INDEX
  } acd_step_t;

endpackage

/* File: logic/acd_exec.sv */
/*
  Execution sequencer for the add/compare/decrement/port-read subset of an
  8-bit microprogrammed CPU, with its accumulator, index register, zero flag,
  program counter and ALU.
  Assumes memory and port devices on the same clock that return read data
  combinationally during the second cycle of a read; other opcodes are skipped.
*/
// Contract
// - Every instruction opens with three fetch cycles
// - Operand latch to address latch, memory strobe
// - Hold address and strobe, capture data next
// - Second byte captured, program counter advances
// - Add immediate: six cycles, counter plus two
// - ALU first input accumulator, sum written back
// - Direct compare: nine cycles, zero on equal
// - Compare accumulator sets zero, four cycles
// - Compare index register: four cycles
// - Indirect compare: seven cycles, counter plus one
// - Immediate compare: six cycles, counter plus two
// - Compare leaves accumulator and index untouched
// - Zero flag taken from ALU zero output, set to one directly for compare accumulator
// - Direct decrement: load, decrement, eleven cycles
// - Accumulator decrement: four cycles
// - Index decrement via accumulator, seven cycles
// - Indirect decrement: nine cycles, counter plus one
// - Immediate decrement: eight cycles, counter plus two
// - Direct port read into accumulator, nine cycles
// - Port strobe with address, data next cycle
// - Operation upper five bits, mode lower three
`timescale 1ns/10ps
module acd_exec
(
  input wire logic core_clk,
  input wire logic rst_b,
  output logic [acd_pkg::DATA_W-1:0] mem_addr,
  output logic memory_read_strobe,
  input wire logic [acd_pkg::DATA_W-1:0] mem_data,
  output logic [acd_pkg::DATA_W-1:0] port_addr,
  output logic port_read_strobe,
  input wire logic [acd_pkg::DATA_W-1:0] port_data,
  output logic [acd_pkg::DATA_W-1:0] acc,
  output logic [acd_pkg::DATA_W-1:0] index,
  output logic zero_flag,
  output logic [acd_pkg::DATA_W-1:0] program_counter,
  output logic instr_start
);
  import acd_pkg::*;

  acd_step_t step_reg;
  acd_step_t step_next;
  logic [DATA_W-1:0] address_latch_reg;
  logic [DATA_W-1:0] fetched_byte_latch_reg;
  logic [DATA_W-1:0] opcode_holding_latch_reg;
  logic [DATA_W-1:0] operand_latch_reg;
  logic [DATA_W-1:0] acc_reg;
  logic [DATA_W-1:0] index_reg;
  logic [DATA_W-1:0] pc_reg;
  logic zero_reg;
  logic [OP_W-1:0] op;
  logic [MODE_W-1:0] mode;
  logic [OP_W-1:0] new_op;
  logic [MODE_W-1:0] new_mode;
  logic is_port;
  logic [DATA_W-1:0] alu_a;
  logic [DATA_W-1:0] alu_b;
  logic [DATA_W-1:0] alu_f;
  logic alu_zero;

  assign op = opcode_holding_latch_reg[OP_HI:OP_LO];
  assign mode = opcode_holding_latch_reg[MODE_HI:MODE_LO];
  assign new_op = fetched_byte_latch_reg[OP_HI:OP_LO];
  assign new_mode = fetched_byte_latch_reg[MODE_HI:MODE_LO];
  assign is_port = (op == OP_PORT_READ);

  // First step after the opcode is known; unsupported opcodes fall back to fetch
  function automatic acd_step_t entry_step(input logic [OP_W-1:0] o, input logic [MODE_W-1:0] m);
    acd_step_t s;
    s = ST_FETCH_ADDR;
    case (m)
      MODE_DIRECT:
        if (o == OP_COMPARE || o == OP_MINUS_ONE || o == OP_PORT_READ)
          s = ST_B2_ADDR;
      MODE_IMMEDIATE:
        if (o == OP_COMPARE || o == OP_MINUS_ONE || o == OP_ADD)
          s = ST_B2_ADDR;
      MODE_INDIRECT:
        if (o == OP_COMPARE || o == OP_MINUS_ONE)
          s = ST_OPND_FROM_INDEX;
      MODE_REG_ACC:
        if (o == OP_COMPARE || o == OP_MINUS_ONE)
          s = ST_EXEC;
      MODE_REG_INDEX:
        if (o == OP_COMPARE)
          s = ST_EXEC;
        else if (o == OP_MINUS_ONE)
          s = ST_LOAD_ACC;
      default:
        s = ST_FETCH_ADDR;
    endcase
    return s;
  endfunction

  always_comb
  begin
    step_next = ST_FETCH_ADDR;
    case (step_reg)
      ST_FETCH_ADDR: step_next = ST_FETCH_DATA;
      ST_FETCH_DATA: step_next = ST_FETCH_LOAD;
      ST_FETCH_LOAD: step_next = entry_step(new_op, new_mode);
      ST_B2_ADDR: step_next = ST_B2_DATA;
      ST_B2_DATA:
        if (mode == MODE_DIRECT)
          step_next = ST_MOVE_OPND;
        else if (op == OP_MINUS_ONE)
          step_next = ST_LOAD_ACC;
        else
          step_next = ST_EXEC;
      ST_MOVE_OPND: step_next = ST_OPND_ADDR;
      ST_OPND_FROM_INDEX: step_next = ST_OPND_ADDR;
      ST_OPND_ADDR: step_next = ST_OPND_DATA;
      ST_OPND_DATA: step_next = (op == OP_COMPARE) ? ST_EXEC : ST_LOAD_ACC;
      ST_LOAD_ACC: step_next = is_port ? ST_FETCH_ADDR : ST_DEC_HOLD;
      ST_DEC_HOLD: step_next = ST_EXEC;
      ST_EXEC:
        if (op == OP_MINUS_ONE && mode == MODE_REG_INDEX)
          step_next = ST_ACC_TO_INDEX;
        else
          step_next = ST_FETCH_ADDR;
      ST_ACC_TO_INDEX: step_next = ST_FETCH_ADDR;
      default: step_next = ST_FETCH_ADDR;
    endcase
  end

  always_ff @(posedge core_clk)
    if (!rst_b)
      step_reg <= ST_FETCH_ADDR;
    else
      step_reg <= step_next;

  // Address latch loads at the end of the address cycle and holds through the data cycle
  always_ff @(posedge core_clk)
    if (!rst_b)
      address_latch_reg <= RST_BYTE;
    else if (step_reg == ST_FETCH_ADDR || step_reg == ST_B2_ADDR)
      address_latch_reg <= pc_reg;
    else if (step_reg == ST_OPND_ADDR)
      address_latch_reg <= operand_latch_reg;

  always_ff @(posedge core_clk)
    if (!rst_b)
      operand_latch_reg <= RST_BYTE;
    else if (step_reg == ST_MOVE_OPND)
      operand_latch_reg <= fetched_byte_latch_reg;
    else if (step_reg == ST_OPND_FROM_INDEX)
      operand_latch_reg <= index_reg;

  always_ff @(posedge core_clk)
    if (!rst_b)
      fetched_byte_latch_reg <= RST_BYTE;
    else if (step_reg == ST_FETCH_DATA || step_reg == ST_B2_DATA)
      fetched_byte_latch_reg <= mem_data;
    else if (step_reg == ST_OPND_DATA)
      fetched_byte_latch_reg <= is_port ? port_data : mem_data;

  always_ff @(posedge core_clk)
    if (!rst_b)
      opcode_holding_latch_reg <= RST_BYTE;
    else if (step_reg == ST_FETCH_LOAD)
      opcode_holding_latch_reg <= fetched_byte_latch_reg;

  always_ff @(posedge core_clk)
    if (!rst_b)
      pc_reg <= RST_BYTE;
    else if (step_reg == ST_FETCH_DATA || step_reg == ST_B2_DATA)
      pc_reg <= pc_reg + ONE_BYTE;

  // ALU: first input is always the accumulator
  always_comb
  begin
    alu_a = acc_reg;
    if (op == OP_MINUS_ONE)
      alu_b = ONE_BYTE;
    else if (mode == MODE_REG_ACC)
      alu_b = acc_reg;
    else if (mode == MODE_REG_INDEX)
      alu_b = index_reg;
    else
      alu_b = fetched_byte_latch_reg;
    alu_f = (op == OP_ADD) ? alu_a + alu_b : alu_a - alu_b;
  end

  assign alu_zero = (alu_f == RST_BYTE);

  // Compare never writes the accumulator, so its difference is simply dropped
  always_ff @(posedge core_clk)
    if (!rst_b)
      acc_reg <= RST_BYTE;
    else if (step_reg == ST_LOAD_ACC)
      acc_reg <= (mode == MODE_REG_INDEX) ? index_reg : fetched_byte_latch_reg;
    else if (step_reg == ST_EXEC && op != OP_COMPARE)
      acc_reg <= alu_f;

  always_ff @(posedge core_clk)
    if (!rst_b)
      index_reg <= RST_BYTE;
    else if (step_reg == ST_ACC_TO_INDEX)
      index_reg <= acc_reg;

  always_ff @(posedge core_clk)
    if (!rst_b)
      zero_reg <= 1'b0;
    else if (step_reg == ST_EXEC && op == OP_COMPARE)
      zero_reg <= (mode == MODE_REG_ACC) ? 1'b1 : alu_zero;

  // Strobes are combinational from the step so they cover both cycles of a read
  assign memory_read_strobe = (step_reg == ST_FETCH_ADDR) || (step_reg == ST_FETCH_DATA)
    || (step_reg == ST_B2_ADDR) || (step_reg == ST_B2_DATA)
    || (!is_port && (step_reg == ST_OPND_ADDR || step_reg == ST_OPND_DATA));
  assign port_read_strobe = is_port && (step_reg == ST_OPND_ADDR || step_reg == ST_OPND_DATA);
  assign mem_addr = address_latch_reg;
  assign port_addr = address_latch_reg;
  assign acc = acc_reg;
  assign index = index_reg;
  assign zero_flag = zero_reg;
  assign program_counter = pc_reg;
  assign instr_start = (step_reg == ST_FETCH_ADDR);

  // Checking helpers: length and program counter change of the instruction just ended
  logic [7:0] len_cnt_reg;
  logic [DATA_W-1:0] pc_start_reg;
  logic started_reg;

  always_ff @(posedge core_clk)
    if (!rst_b)
    begin
      len_cnt_reg <= LEN_ONE;
      pc_start_reg <= RST_BYTE;
      started_reg <= 1'b0;
    end
    else
    begin
      len_cnt_reg <= (step_reg == ST_FETCH_ADDR) ? LEN_ONE : len_cnt_reg + LEN_ONE;
      if (step_reg == ST_FETCH_ADDR)
        pc_start_reg <= pc_reg;
      if (step_reg == ST_FETCH_LOAD)
        started_reg <= 1'b1;
    end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  AST_FETCH_SEQ: assert property (
    // Reset level in the antecedent keeps the attempt at the releasing edge from starting a false sequence
    step_reg == ST_FETCH_ADDR && rst_b |-> memory_read_strobe ##1 (memory_read_strobe && mem_addr == $past(pc_reg))
      ##1 (step_reg == ST_FETCH_LOAD))
    else $error("opcode fetch sequence broken");

  AST_OPERAND_ADDR: assert property (
    step_reg == ST_OPND_ADDR && !is_port |=> mem_addr == $past(operand_latch_reg) && memory_read_strobe)
    else $error("operand address not driven from operand latch");

  AST_HOLD_ADDR: assert property (
    step_reg == ST_OPND_DATA && !is_port |-> memory_read_strobe ##1 fetched_byte_latch_reg == $past(mem_data))
    else $error("memory data cycle not held or captured");

  AST_B2_PC: assert property (
    step_reg == ST_B2_DATA |=> pc_reg == $past(pc_reg) + ONE_BYTE && fetched_byte_latch_reg == $past(mem_data))
    else $error("second byte fetch wrong");

  AST_ADDI_LEN: assert property (
    step_reg == ST_FETCH_ADDR && started_reg && opcode_holding_latch_reg == OPC_ADD_IMM
      |-> len_cnt_reg == 8'(CYC_ADD_IMM) && pc_reg == pc_start_reg + TWO_BYTE)
    else $error("add immediate length or counter wrong");

  AST_CMPD_LEN: assert property (
    step_reg == ST_FETCH_ADDR && started_reg && opcode_holding_latch_reg == OPC_CMP_DIR
      |-> len_cnt_reg == 8'(CYC_CMP_DIR) && pc_reg == pc_start_reg + TWO_BYTE)
    else $error("direct compare length or counter wrong");

  AST_CMPA_Z: assert property (
    step_reg == ST_EXEC && op == OP_COMPARE && mode == MODE_REG_ACC |=> zero_reg ##1 step_reg == ST_FETCH_DATA)
    else $error("compare accumulator did not set zero");

  AST_CMP_KEEP: assert property (
    step_reg == ST_EXEC && op == OP_COMPARE |=> $stable(acc_reg) && $stable(index_reg))
    else $error("compare changed a data register");

  AST_CMP_ZERO: assert property (
    step_reg == ST_EXEC && op == OP_COMPARE && mode != MODE_REG_ACC |=> zero_reg == (($past(acc_reg) - $past(alu_b)) == RST_BYTE))
    else $error("zero flag not from subtraction");

  AST_DECD_LEN: assert property (
    step_reg == ST_FETCH_ADDR && started_reg && opcode_holding_latch_reg == OPC_DEC_DIR
      |-> len_cnt_reg == 8'(CYC_DEC_DIR) && pc_reg == pc_start_reg + TWO_BYTE)
    else $error("direct decrement length or counter wrong");

  AST_DECR_EQUAL: assert property (
    step_reg == ST_ACC_TO_INDEX |=> index_reg == acc_reg && step_reg == ST_FETCH_ADDR)
    else $error("index decrement left registers unequal");

  AST_PORT_SEQ: assert property (
    step_reg == ST_OPND_ADDR && is_port |=> port_read_strobe && !memory_read_strobe
      ##1 fetched_byte_latch_reg == $past(port_data) ##1 acc_reg == $past(fetched_byte_latch_reg))
    else $error("port read sequence wrong");

  AST_PORT_LEN: assert property (
    step_reg == ST_FETCH_ADDR && started_reg && opcode_holding_latch_reg == OPC_PORT_DIR
      |-> len_cnt_reg == 8'(CYC_PORT_DIR))
    else $error("port read length wrong");

  AST_ZERO_DEF: assert property (
    // Independent of the subtractor: a difference is zero only for equal inputs
    op != OP_ADD |-> alu_zero == (alu_a == alu_b))
    else $error("ALU zero output wrong");

endmodule

/* File: verification/acd_mem_model.sv */
/*
  Partner model: byte-wide memory and port spaces, each read with its own strobe.
  Assumes two-cycle reads with the data taken at the edge that ends the second
  cycle; the bench loads both arrays through hierarchy before reset is released.
*/
`timescale 1ns/10ps
module acd_mem_model
(
  input wire logic core_clk,
  input wire logic [acd_pkg::DATA_W-1:0] mem_addr,
  input wire logic memory_read_strobe,
  output logic [acd_pkg::DATA_W-1:0] mem_data,
  input wire logic [acd_pkg::DATA_W-1:0] port_addr,
  input wire logic port_read_strobe,
  output logic [acd_pkg::DATA_W-1:0] port_data
);
  import acd_pkg::*;
  logic [DATA_W-1:0] mem_array [0:255];
  logic [DATA_W-1:0] port_array [0:255];
  logic [DATA_W-1:0] mem_last_reg = 8'h3c;
  logic [DATA_W-1:0] port_last_reg = 8'h5a;
  // A released bus shows a changing pattern, so a sample taken without the strobe is caught
  always_comb
  begin
    mem_data = memory_read_strobe ? mem_array[mem_addr] : ~mem_last_reg;
    port_data = port_read_strobe ? port_array[port_addr] : ~port_last_reg;
  end
  always @(posedge core_clk)
  begin
    mem_last_reg <= mem_data;
    port_last_reg <= port_data;
  end
endmodule

/* File: verification/tb_add_compare_decrement_exec.sv */
/*
  Self-checking bench: runs a short program through the sequencer and checks
  the length of every instruction and the state that it leaves behind.
  Assumes the partner model answers reads with no wait states.
*/
`timescale 1ns/10ps
module tb_add_compare_decrement_exec;
  import acd_pkg::*;
  localparam int N_INSTR = 18;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [DATA_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_data;
  logic [DATA_W-1:0] port_addr;
  logic [DATA_W-1:0] port_data;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] index;
  logic [DATA_W-1:0] program_counter;
  logic memory_read_strobe;
  logic port_read_strobe;
  logic zero_flag;
  logic instr_start;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc;
  logic [7:0] prog [0:26] = '{8'h66, 8'h05, 8'h3e, 8'h05, 8'h3e, 8'h04, 8'h73, 8'h3b, 8'h72,
    8'h3b, 8'h3a, 8'h74, 8'h3c, 8'h38, 8'h90, 8'h70, 8'h80, 8'h76, 8'h01, 8'h08, 8'h22, 8'h66,
    8'h5b, 8'h3e, 8'h01, 8'h10, 8'h3a};
  int exp_len [0:N_INSTR-1] = '{6, 6, 6, 7, 4, 4, 4, 4, 9, 7, 9, 11, 8, 9, 6, 6, 3, 4};
  logic [7:0] exp_acc [0:N_INSTR-1] = '{8'h05, 8'h05, 8'h05, 8'hff, 8'hff, 8'hfe, 8'hfe, 8'hfe,
    8'h3f, 8'h3f, 8'h3f, 8'hff, 8'h00, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] exp_pc [0:N_INSTR-1] = '{8'h02, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b,
    8'h0c, 8'h0d, 8'h0f, 8'h11, 8'h13, 8'h15, 8'h17, 8'h19, 8'h1a, 8'h1b};
  // Zero flag after each instruction; the pattern flips often so a stuck flag shows up
  logic [0:N_INSTR-1] exp_z = 18'h136f9;

  acd_exec dut
  (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .mem_addr(mem_addr),
    .memory_read_strobe(memory_read_strobe),
    .mem_data(mem_data),
    .port_addr(port_addr),
    .port_read_strobe(port_read_strobe),
    .port_data(port_data),
    .acc(acc),
    .index(index),
    .zero_flag(zero_flag),
    .program_counter(program_counter),
    .instr_start(instr_start)
  );

  acd_mem_model model
  (
    .core_clk(core_clk),
    .mem_addr(mem_addr),
    .memory_read_strobe(memory_read_strobe),
    .mem_data(mem_data),
    .port_addr(port_addr),
    .port_read_strobe(port_read_strobe),
    .port_data(port_data)
  );

  always #5 core_clk = ~core_clk;

  task automatic results();
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Counts edges up to the next instruction start; a hang ends the run
  task automatic run_one(output int n);
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (instr_start !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      n_errors++;
      results();
    end
  endtask

  initial
  begin
    for (int a = 0; a < 256; a++)
    begin
      model.mem_array[a] = (a < 27) ? prog[a] : 8'h00;
      model.port_array[a] = 8'h00;
    end
    model.mem_array[8'hff] = 8'h40;
    model.mem_array[8'h90] = 8'h3f;
    model.mem_array[8'h80] = 8'h00;
    // Memory holds a different byte at the port address, so a wrong strobe is seen
    model.mem_array[8'h22] = 8'h5a;
    model.port_array[8'h22] = 8'ha5;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    #1;
    check_bit("instr_start", 1'b1, instr_start);
    for (int i = 0; i < N_INSTR; i++)
    begin
      run_one(cyc);
      check_byte("cycles", 8'(exp_len[i]), 8'(cyc));
      check_byte("acc", exp_acc[i], acc);
      check_byte("index", (i < 3) ? 8'h00 : 8'hff, index);
      check_bit("zero_flag", exp_z[i], zero_flag);
      check_byte("program_counter", exp_pc[i], program_counter);
      check_bit("memory_read_strobe", 1'b1, memory_read_strobe);
      check_bit("port_read_strobe", 1'b0, port_read_strobe);
    end
    // Last fetch address stays on the shared address latch
    check_byte("mem_addr", 8'h1a, mem_addr);
    check_byte("port_addr", 8'h1a, port_addr);
    // Reset again in mid-fetch: accumulator, index, counter and zero flag return to zero
    @(posedge core_clk);
    rst_b <= 1'b0;
    @(posedge core_clk);
    #1;
    check_byte("acc", 8'h00, acc);
    check_byte("index", 8'h00, index);
    check_byte("program_counter", 8'h00, program_counter);
    check_bit("zero_flag", 1'b0, zero_flag);
    check_bit("instr_start", 1'b1, instr_start);
    // Release again: the sequencer restarts from address zero
    @(posedge core_clk);
    rst_b <= 1'b1;
    run_one(cyc);
    check_byte("cycles", 8'h06, 8'(cyc));
    check_byte("acc", 8'h05, acc);
    check_byte("program_counter", 8'h02, program_counter);
    results();
  end
endmodule
